// >>> rcr_defines.vh
// Purpose: Constants for the reset cause and control register block
// Assumes: One 16-bit control register and two 9-bit interrupt registers on a 32-bit classic Wishbone slave
// Notes: Offsets are byte addresses
`ifndef RCR_DEFINES_VH
`define RCR_DEFINES_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RCR_OFS_CTRL 4'h0
`define RCR_OFS_IRQ_STAT 4'h4
`define RCR_OFS_IRQ_MASK 4'h8
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RCR_B_TRAP 15
`define RCR_B_ILLOP 14
`define RCR_B_SBOR 13
`define RCR_B_RETENTION_SLEEP_SELECT 12
`define RCR_B_UNIMP 11
`define RCR_B_DSLP 10
`define RCR_B_CFGM 9
`define RCR_B_PROGMEM_SLEEP_POWER 8
`define RCR_B_PIN 7
`define RCR_B_SWRST 6
`define RCR_B_SWDT 5
`define RCR_B_WATCHDOG_TIMEOUT_FLAG 4
`define RCR_B_SLEEP 3
`define RCR_B_IDLE 2
`define RCR_B_BOR 1
`define RCR_B_POR 0
// ---------------------------------------------------------------
// Reset values and masks
// ---------------------------------------------------------------
`define RCR_CTRL_RST 16'h0003
`define RCR_CTRL_WMASK 16'hF7FF
`define RCR_EVT_W 9
`endif

// >>> rcr_reset_cause.v
// What this block does
// - Trap conflict reset sets bit 15
// - Illegal opcode sets bit 14, power-on clears
// - Bit 12 selects retention regulator in sleep
// - Deep sleep sets bit 10; software clears
// - Configuration mismatch reset sets bit 9
// - Bit 8 keeps program memory powered asleep
// - Reset instruction sets bit 6
// - Power-on clears all but brown-out, power-on
// - Software flag writes never cause reset
// - Unprogrammed watchdog fuse forces watchdog on
//
// Purpose: Reset cause status and power control register
// Assumes: Event inputs are one-clock pulses on clk_i; rst_i is power-on reset
// Notes: Hardware set wins over a software clear in the same cycle
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defines.vh"
module rcr_reset_cause (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   output reg err_o,
   // Hardware events, one-cycle pulses
   input wire trap_conflict_i,
   input wire illegal_op_i,
   input wire deep_sleep_i,
   input wire config_mismatch_i,
   input wire pin_reset_i,
   input wire sw_reset_i,
   input wire watchdog_timeout_i,
   input wire sleep_entry_i,
   input wire idle_entry_i,
   input wire brownout_i,
   // Fuse level, from the configuration logic
   input wire watchdog_fuse_enable_i,
   // Control outputs
   output reg sw_brownout_enable_o,
   output reg retention_sleep_select_o,
   output reg progmem_sleep_power_o,
   output reg regulator_standby_o,
   output reg watchdog_enable_o,
   output reg irq_o
);
   reg [15:0] reset_cause_control;
   reg [`RCR_EVT_W-1:0] irq_stat;
   reg [`RCR_EVT_W-1:0] irq_mask;
   reg [15:0] hw_set;
   reg [15:0] next_ctrl;
   reg [`RCR_EVT_W-1:0] evt;
   reg [`RCR_EVT_W-1:0] next_stat;
   wire req = cyc_i & stb_i & ~ack_o & ~err_o;
   wire hit_ctrl = (adr_i == `RCR_OFS_CTRL);
   wire hit_stat = (adr_i == `RCR_OFS_IRQ_STAT);
   wire hit_mask = (adr_i == `RCR_OFS_IRQ_MASK);
   wire wr = req & we_i;

   // Byte-lane merge of a 16-bit register
   function [15:0] lane_merge;
      input [15:0] old;
      input [15:0] new_v;
      input [1:0] sel;
      begin
         lane_merge = old;
         if (sel[0]) begin
            lane_merge[7:0] = new_v[7:0];
         end
         if (sel[1]) begin
            lane_merge[15:8] = new_v[15:8];
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // Hardware set terms
   // ---------------------------------------------------------------
   always @* begin
      hw_set = 16'h0000;
      hw_set[`RCR_B_TRAP] = trap_conflict_i;
      hw_set[`RCR_B_ILLOP] = illegal_op_i;
      hw_set[`RCR_B_DSLP] = deep_sleep_i;
      hw_set[`RCR_B_CFGM] = config_mismatch_i;
      hw_set[`RCR_B_PIN] = pin_reset_i;
      hw_set[`RCR_B_SWRST] = sw_reset_i;
      hw_set[`RCR_B_WATCHDOG_TIMEOUT_FLAG] = watchdog_timeout_i;
      hw_set[`RCR_B_SLEEP] = sleep_entry_i;
      hw_set[`RCR_B_IDLE] = idle_entry_i;
      hw_set[`RCR_B_BOR] = brownout_i;
      evt = {trap_conflict_i, illegal_op_i, deep_sleep_i, config_mismatch_i,
         pin_reset_i, sw_reset_i, watchdog_timeout_i, brownout_i, sleep_entry_i};
   end

   // ---------------------------------------------------------------
   // Next register value
   // ---------------------------------------------------------------
   always @* begin
      next_ctrl = reset_cause_control;
      if (wr && hit_ctrl) begin
         // Plain store; nothing here feeds a reset request
         next_ctrl = lane_merge(reset_cause_control, dat_i[15:0], sel_i[1:0]);
         // Deep sleep flag may only be cleared by software
         if (sel_i[1]) begin
            next_ctrl[`RCR_B_DSLP] = reset_cause_control[`RCR_B_DSLP]
               & dat_i[`RCR_B_DSLP];
         end
      end
      // Hardware set wins over a same-cycle clear
      next_ctrl = (next_ctrl | hw_set) & `RCR_CTRL_WMASK;
   end

   always @* begin
      next_stat = irq_stat;
      if (wr && hit_stat && sel_i[0]) begin
         next_stat = irq_stat & ~dat_i[`RCR_EVT_W-1:0];
      end
      if (wr && hit_stat && sel_i[1]) begin
         next_stat[`RCR_EVT_W-1] = irq_stat[`RCR_EVT_W-1] & ~dat_i[`RCR_EVT_W-1];
      end
      next_stat = next_stat | evt;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         reset_cause_control <= `RCR_CTRL_RST;
         irq_stat <= {`RCR_EVT_W{1'b0}};
         irq_mask <= {`RCR_EVT_W{1'b0}};
      end else begin
         reset_cause_control <= next_ctrl;
         irq_stat <= next_stat;
         if (wr && hit_mask) begin
            if (sel_i[0]) begin
               irq_mask[7:0] <= dat_i[7:0];
            end
            if (sel_i[1]) begin
               irq_mask[`RCR_EVT_W-1] <= dat_i[`RCR_EVT_W-1];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus answer, one wait-free cycle after the request
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= req & (hit_ctrl | hit_stat | hit_mask);
         err_o <= req & ~(hit_ctrl | hit_stat | hit_mask);
         dat_o <= 32'h00000000;
         if (req && !we_i && hit_ctrl) begin
            dat_o <= {16'h0000, reset_cause_control};
         end else if (req && !we_i && hit_stat) begin
            dat_o <= {23'h000000, irq_stat};
         end else if (req && !we_i && hit_mask) begin
            dat_o <= {23'h000000, irq_mask};
         end
      end
   end

   // ---------------------------------------------------------------
   // Control outputs, registered from the next register values
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         sw_brownout_enable_o <= 1'b0;
         retention_sleep_select_o <= 1'b0;
         progmem_sleep_power_o <= 1'b0;
         regulator_standby_o <= 1'b0;
         watchdog_enable_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         sw_brownout_enable_o <= next_ctrl[`RCR_B_SBOR];
         // Only meaningful on high-voltage variants
         retention_sleep_select_o <= next_ctrl[`RCR_B_RETENTION_SLEEP_SELECT];
         progmem_sleep_power_o <= next_ctrl[`RCR_B_PROGMEM_SLEEP_POWER];
         regulator_standby_o <= ~next_ctrl[`RCR_B_PROGMEM_SLEEP_POWER];
         // Fuse level is static, so no synchroniser
         watchdog_enable_o <= watchdog_fuse_enable_i
            | next_ctrl[`RCR_B_SWDT];
         irq_o <= |(next_stat & irq_mask);
      end
   end
endmodule
`default_nettype wire

// >>> rcr_reset_cause_properties.sv
// Purpose: Port checker for rcr_reset_cause
// Assumes: Master holds request until ack
// Notes: One clock domain
`timescale 1ns/100ps
`default_nettype none
module rcr_reset_cause_chk (
   // Clock, reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic err_o,
   // Controls
   input wire logic watchdog_fuse_enable_i,
   input wire logic retention_sleep_select_o,
   input wire logic progmem_sleep_power_o,
   input wire logic regulator_standby_o,
   input wire logic watchdog_enable_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o && !err_o && adr_i == 4'h0;
   endsequence
   sequence s_wr_hi;
      s_take ##0 (we_i && sel_i[1]);
   endsequence
   a_standby_inverse: assert property (!$past(rst_i) |-> regulator_standby_o != progmem_sleep_power_o)
      else $error("standby not inverse");
   a_fuse_forces_wdt: assert property (watchdog_fuse_enable_i |=> watchdog_enable_o)
      else $error("fuse did not force watchdog");
   a_wdt_fall_cause: assert property ($fell(watchdog_enable_o) |-> !$past(watchdog_fuse_enable_i))
      else $error("watchdog off with fuse set");
   a_ret_write: assert property (s_wr_hi |=> retention_sleep_select_o == dat_i[12])
      else $error("retention select wrong");
   a_pm_write: assert property (s_wr_hi |=> progmem_sleep_power_o == dat_i[8])
      else $error("progmem power wrong");
   a_pm_change_cause: assert property ($changed(progmem_sleep_power_o) |-> ack_o && we_i)
      else $error("progmem power changed alone");
   a_flag_write_acks: assert property (s_take ##0 we_i |=> (ack_o && !err_o) ##1 !ack_o)
      else $error("control write not acked once");
   a_reset_values: assert property ($past(rst_i) |-> !irq_o && !progmem_sleep_power_o)
      else $error("outputs not cleared by reset");
   a_unimp_zero: assert property (s_take ##0 !we_i |=> !dat_o[11] && dat_o[31:16] == 16'h0000)
      else $error("unimplemented bits not zero");
endmodule
bind rcr_reset_cause rcr_reset_cause_chk rcr_reset_cause_chk_inst (.*);
`default_nettype wire

// >>> rcr_reset_cause_tb_top.sv
// Purpose: Self-checking bench for rcr_reset_cause
// Assumes: Events are one-clock pulses
// Notes: Bus tasks speak classic Wishbone
`timescale 1ns/100ps
`default_nettype none
module rcr_reset_cause_tb_top;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, watchdog_fuse_enable_i, ack_o, err_o, e, irq_o;
   logic [3:0] adr_i, sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic sw_brownout_enable_o, retention_sleep_select_o, progmem_sleep_power_o;
   logic regulator_standby_o, watchdog_enable_o;
   logic trap_conflict_i, illegal_op_i, deep_sleep_i, config_mismatch_i, pin_reset_i;
   logic sw_reset_i, watchdog_timeout_i, sleep_entry_i, idle_entry_i, brownout_i;
   logic [9:0] ev;
   int error_cnt = 0;
   int n_checks = 0;
   int pos[10] = '{15, 14, 10, 9, 7, 6, 4, 3, 2, 1};
   assign {brownout_i, idle_entry_i, sleep_entry_i, watchdog_timeout_i, sw_reset_i,
      pin_reset_i, config_mismatch_i, deep_sleep_i, illegal_op_i, trap_conflict_i} = ev;
   rcr_reset_cause rcr_reset_cause_inst (.*);
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic give_verdict;
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   // Bus cycle, one idle cycle after ack
   // No own limit on the wait: only the watchdog ends a hung cycle
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'h3, d};
      do begin
         @(posedge clk_i);
      end while (!ack_o && !err_o);
      q = dat_o;
      e = err_o;
      {cyc_i, stb_i} <= 2'h0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic pulse(input int i);
      ev <= 10'h001 << i;
      @(posedge clk_i);
      ev <= 10'h000;
      @(posedge clk_i);
   endtask
   initial begin
      {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, ev} = {4'h8, 8'h00, 32'h0, 10'h000};
      watchdog_fuse_enable_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(4'h0, 32'h0003);
      chk_b(regulator_standby_o, 1'b1);
      chk_b(progmem_sleep_power_o, 1'b0);
      chk_b(sw_brownout_enable_o, 1'b0);
      wb(1'b1, 4'h0, 32'hFFFF);
      watchdog_fuse_enable_i <= 1'b0;
      rd(4'h0, 32'hF3FF);
      chk_b(retention_sleep_select_o, 1'b1);
      chk_b(regulator_standby_o, 1'b0);
      chk_b(progmem_sleep_power_o, 1'b1);
      chk_b(sw_brownout_enable_o, 1'b1);
      chk_b(watchdog_enable_o, 1'b1);
      wb(1'b1, 4'h0, 32'h0000);
      rd(4'h0, 32'h0000);
      chk_b(watchdog_enable_o, 1'b0);
      chk_b(retention_sleep_select_o, 1'b0);
      watchdog_fuse_enable_i <= 1'b1;
      pulse(0);
      chk_b(irq_o, 1'b0);
      wb(1'b1, 4'h8, 32'h01FF);
      chk_b(irq_o, 1'b1);
      chk_b(watchdog_enable_o, 1'b1);
      for (int i = 0; i < 10; i++) begin
         wb(1'b1, 4'h4, 32'h01FF);
         wb(1'b1, 4'h0, 32'h0000);
         chk_b(irq_o, 1'b0);
         pulse(i);
         chk_b(irq_o, i != 8);
         rd(4'h0, 32'h0001 << pos[i]);
      end
      wb(1'b0, 4'hC, 32'h0);
      chk_b(e, 1'b1);
      pulse(1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(4'h0, 32'h0003);
      give_verdict;
   end
   initial begin
      #75000;
      error_cnt++;
      $display("MISMATCH %0t timeout", $time);
      give_verdict;
   end
endmodule
`default_nettype wire
